// *** nif_pkg.sv ***
// constants, types and the rule summary for the nfc interrupt flag block
// What this block does
// - oscillator-stable flag, main bit 7, set once started oscillator becomes stable
// - fifo level flag set while receiving with more than 300 bytes buffered
// - fifo level flag set while transmitting with fewer than 200 bytes left
// - main bits 5,4,3,2 latch rx start, rx end, tx end, collision
// - restart flag set when a disturbance frame is dropped and reception restarts
// - timer bits 7,6,5 latch command done, no-response and general timer expiry
// - separate flags for external field rising above and falling below level
// - collision-avoidance collision flagged; host reads it clear before starting avoidance
// - guard-time flag only after own field on and minimum guard time elapsed
// - target mode bit-rate-recognized flag set once initiator rate identified
// - reading timer or target register returns flags then clears them
// - reading main register clears error register; otherwise it holds
// - soft framing flag separate from crc bit 7 and parity bit 6
// - hard framing error reported in error register bit 4
// - wake timer flag on timeout only when flag-every-timeout option selected
// - separate flags for amplitude, phase, capacitance reference deviations
// - slot low flag raised when four unused slot numbers remain
// - field-on event flag after collision-free avoidance turned own field on
// - target end-of-receive flag when automatic anticollision or sensf answer sent
// - 212/424 target-active flag after automatic sensf_req answer sent
// - separate flags for entering type-a active and starred active states
// - mask bit 1 keeps its flag off the interrupt request
package nif_pkg;

  // register offsets
  localparam logic [7:0] ADDR_GUARD = 8'h15;
  localparam logic [7:0] ADDR_MASK_MAIN = 8'h16;
  localparam logic [7:0] ADDR_MASK_TF = 8'h17;
  localparam logic [7:0] ADDR_MASK_ERR = 8'h18;
  localparam logic [7:0] ADDR_MASK_TGT = 8'h19;
  localparam logic [7:0] ADDR_MAIN = 8'h1a;
  localparam logic [7:0] ADDR_TF = 8'h1b;
  localparam logic [7:0] ADDR_ERR = 8'h1c;
  localparam logic [7:0] ADDR_TGT = 8'h1d;

  // main register bit positions
  localparam int MAIN_OSC = 7;
  localparam int MAIN_FIFO = 6;
  localparam int MAIN_RXS = 5;
  localparam int MAIN_RXE = 4;
  localparam int MAIN_TXE = 3;
  localparam int MAIN_COL = 2;
  localparam int MAIN_REST = 1;

  // timer and field register bit positions
  localparam int TF_DCT = 7;
  localparam int TF_NRE = 6;
  localparam int TF_GPE = 5;
  localparam int TF_EON = 4;
  localparam int TF_EOF = 3;
  localparam int TF_CAC = 2;
  localparam int TF_CAT = 1;
  localparam int TF_RATE = 0;

  // error and wake-up register bit positions
  localparam int ERR_CRC = 7;
  localparam int ERR_PAR = 6;
  localparam int ERR_SOFT = 5;
  localparam int ERR_HARD = 4;
  localparam int ERR_WT = 3;
  localparam int ERR_WAM = 2;
  localparam int ERR_WPH = 1;
  localparam int ERR_WCAP = 0;

  // target register bit positions
  localparam int TGT_SLOT = 6;
  localparam int TGT_APON = 5;
  localparam int TGT_RXE = 4;
  localparam int TGT_FACT = 3;
  localparam int TGT_ASTAR = 1;
  localparam int TGT_ACT = 0;

  // implemented bits; reserved bits read zero
  localparam logic [7:0] MAIN_USED = 8'hfe;
  localparam logic [7:0] TF_USED = 8'hff;
  localparam logic [7:0] ERR_USED = 8'hff;
  localparam logic [7:0] TGT_USED = 8'h7b;

  // reset values
  localparam logic [7:0] FLAG_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] GUARD_RST = 8'h33;

  // thresholds and state codes
  localparam logic [9:0] FIFO_RX_HIGH = 10'h12c;
  localparam logic [9:0] FIFO_TX_LOW = 10'h0c8;
  localparam logic [4:0] SLOT_LOW = 5'h04;
  localparam logic [3:0] PTA_ACTIVE = 4'h5;
  localparam logic [3:0] PTA_ACTIVE_STAR = 4'hd;

  // guard timing: base time plus register steps
  localparam int CLK_PERIOD_NS = 8;
  localparam int GUARD_BASE_NS = 75000;
  localparam int GUARD_STEP_NS = 151000;
  localparam int GUARD_BASE_CYC = (GUARD_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GUARD_STEP_CYC = (GUARD_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // guard timer states
  typedef enum logic [1:0] {
    GT_IDLE = 2'b00,
    GT_BASE = 2'b01,
    GT_STEP = 2'b10
  } nif_gt_state_t;

endpackage : nif_pkg

// *** nif_flag_if.sv ***
// set, clear and flag vector shared by the top and one flag bank
`timescale 1ns/1ps
`default_nettype none
interface nif_flag_if;
  logic [7:0] set;
  logic [7:0] clr;
  logic [7:0] flags;
  modport bank (input set, input clr, output flags);
  modport ctl (output set, output clr, input flags);
endinterface : nif_flag_if
`default_nettype wire

// *** nif_flag_bank.sv ***
// one 8-bit bank of sticky event flags
`timescale 1ns/1ps
`default_nettype none
module nif_flag_bank
  import nif_pkg::*;
#(
  parameter logic [7:0] USED = 8'hff
) (
  // clock, reset and enable
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // set, clear and flags
  nif_flag_if.bank fl
);

  logic [7:0] flags_q;

  // set beats clear so an event in the clearing cycle survives
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flags_q <= FLAG_RST;
    end else if (ce_i) begin
      flags_q <= ((flags_q & ~fl.clr) | fl.set) & USED;
    end
  end

  assign fl.flags = flags_q;

endmodule : nif_flag_bank
`default_nettype wire

// *** nif_guard_timer.sv ***
// field-on guard timer: base time then a number of register steps
`timescale 1ns/1ps
`default_nettype none
module nif_guard_timer
  import nif_pkg::*;
#(
  parameter int BASE_CYC = GUARD_BASE_CYC,
  parameter int STEP_CYC = GUARD_STEP_CYC
) (
  // clock, reset and enable
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // control
  input wire logic start_i,
  input wire logic [7:0] steps_i,
  output logic done_o
);

  nif_gt_state_t state_q;
  logic [15:0] cnt_q;
  logic [7:0] steps_q;
  logic done_q;

  // a new start restarts the wait; steps are sampled at start only
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= GT_IDLE;
      cnt_q <= 16'h0000;
      steps_q <= 8'h00;
      done_q <= 1'b0;
    end else if (ce_i) begin
      done_q <= 1'b0;
      if (start_i) begin
        state_q <= GT_BASE;
        cnt_q <= 16'h0000;
        steps_q <= steps_i;
      end else begin
        unique case (state_q)
          GT_IDLE: begin
            cnt_q <= 16'h0000;
          end
          GT_BASE: begin
            if (cnt_q == 16'(BASE_CYC - 1)) begin
              cnt_q <= 16'h0000;
              if (steps_q == 8'h00) begin
                state_q <= GT_IDLE;
                done_q <= 1'b1;
              end else begin
                state_q <= GT_STEP;
              end
            end else begin
              cnt_q <= cnt_q + 16'h0001;
            end
          end
          GT_STEP: begin
            if (cnt_q == 16'(STEP_CYC - 1)) begin
              cnt_q <= 16'h0000;
              steps_q <= steps_q - 8'h01;
              if (steps_q == 8'h01) begin
                state_q <= GT_IDLE;
                done_q <= 1'b1;
              end
            end else begin
              cnt_q <= cnt_q + 16'h0001;
            end
          end
          default: begin
            state_q <= GT_IDLE;
          end
        endcase
      end
    end
  end

  assign done_o = done_q;

endmodule : nif_guard_timer
`default_nettype wire

// *** nif_flags_top.sv ***
// nfc interrupt flag registers with masks, read-clear and request output
`timescale 1ns/1ps
`default_nettype none
module nif_flags_top
  import nif_pkg::*;
#(
  parameter int GUARD_BASE_CYCLES = GUARD_BASE_CYC,
  parameter int GUARD_STEP_CYCLES = GUARD_STEP_CYC
) (
  // clock, reset, enable
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // oscillator
  input wire logic osc_en_i,
  input wire logic osc_stable_i,
  // fifo fill state
  input wire logic rx_active_i,
  input wire logic tx_active_i,
  input wire logic [9:0] fifo_count_i,
  // frame events, one-cycle pulses
  input wire logic rx_start_i,
  input wire logic rx_end_i,
  input wire logic tx_end_i,
  input wire logic bit_col_i,
  input wire logic disturbance_frame_i,
  // timer events, one-cycle pulses
  input wire logic cmd_done_i,
  input wire logic nrt_expire_i,
  input wire logic gpt_expire_i,
  // external field and collision avoidance
  input wire logic ext_field_i,
  input wire logic ca_collision_i,
  input wire logic ca_field_on_i,
  input wire logic bitrate_found_i,
  // receive errors, one-cycle pulses
  input wire logic crc_err_i,
  input wire logic parity_err_i,
  input wire logic soft_framing_i,
  input wire logic hard_framing_i,
  // wake-up events
  input wire logic wake_timeout_i,
  input wire logic wake_every_i,
  input wire logic wake_amp_i,
  input wire logic wake_phase_i,
  input wire logic wake_cap_i,
  // passive target
  input wire logic [4:0] unused_slots_i,
  input wire logic pt_auto_resp_i,
  input wire logic nfcf_resp_sent_i,
  input wire logic [3:0] pta_state_i,
  // interrupt request
  output logic irq_o
);

  // rising-edge helper used by the oscillator, fifo, field and slot level sources
  function automatic logic rise(input logic cur, input logic prev);
    rise = cur & ~prev;
  endfunction : rise

  // one flag carrier per register
  nif_flag_if main_if ();
  nif_flag_if tf_if ();
  nif_flag_if err_if ();
  nif_flag_if tgt_if ();

  // software registers
  logic [7:0] mask_main_q;
  logic [7:0] mask_tf_q;
  logic [7:0] mask_err_q;
  logic [7:0] mask_tgt_q;
  logic [7:0] guard_q;
  logic [7:0] rdata_q;
  logic irq_q;

  // previous samples of level sources
  logic osc_ok_q;
  logic fifo_lvl_q;
  logic field_q;
  logic slot_low_q;
  logic [3:0] pta_state_q;

  // decoded conditions
  logic osc_ok;
  logic fifo_lvl;
  logic slot_low;
  logic guard_done;
  logic enter_act;
  logic enter_act_star;

  // read strobes for the main, timer and target registers
  logic rd_main;
  logic rd_tf;
  logic rd_tgt;

  // flag storage banks
  nif_flag_bank #(
    .USED(MAIN_USED)
  ) u_main_bank (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .fl(main_if.bank)
  );

  nif_flag_bank #(
    .USED(TF_USED)
  ) u_tf_bank (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .fl(tf_if.bank)
  );

  nif_flag_bank #(
    .USED(ERR_USED)
  ) u_err_bank (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .fl(err_if.bank)
  );

  nif_flag_bank #(
    .USED(TGT_USED)
  ) u_tgt_bank (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .fl(tgt_if.bank)
  );

  // guard timer is started by the own-field-on event after avoidance
  // steps are taken at start, so a later write waits for the next start
  nif_guard_timer #(
    .BASE_CYC(GUARD_BASE_CYCLES),
    .STEP_CYC(GUARD_STEP_CYCLES)
  ) u_guard (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .start_i(ca_field_on_i),
    .steps_i(guard_q),
    .done_o(guard_done)
  );

  // level conditions; each flag fires once per entry, not every cycle
  assign osc_ok = osc_en_i & osc_stable_i;
  assign fifo_lvl = (rx_active_i & (fifo_count_i > FIFO_RX_HIGH)) |
                    (tx_active_i & (fifo_count_i < FIFO_TX_LOW));
  assign slot_low = (unused_slots_i == SLOT_LOW);
  assign enter_act = (pta_state_i == PTA_ACTIVE) & (pta_state_q != PTA_ACTIVE);
  assign enter_act_star = (pta_state_i == PTA_ACTIVE_STAR) &
                          (pta_state_q != PTA_ACTIVE_STAR);

  // history of level sources for edge detection
  // a level already high at release sets its flag on the first edge
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      osc_ok_q <= 1'b0;
      fifo_lvl_q <= 1'b0;
      field_q <= 1'b0;
      slot_low_q <= 1'b0;
      pta_state_q <= 4'h0;
    end else if (ce_i) begin
      osc_ok_q <= osc_ok;
      fifo_lvl_q <= fifo_lvl;
      field_q <= ext_field_i;
      slot_low_q <= slot_low;
      pta_state_q <= pta_state_i;
    end
  end

  // main register sources
  always_comb begin
    // reserved bit 0 is never set
    main_if.set = 8'h00;

    main_if.set[MAIN_OSC] = rise(osc_ok, osc_ok_q);

    main_if.set[MAIN_FIFO] = rise(fifo_lvl, fifo_lvl_q);

    main_if.set[MAIN_RXS] = rx_start_i;
    main_if.set[MAIN_RXE] = rx_end_i;
    main_if.set[MAIN_TXE] = tx_end_i;
    main_if.set[MAIN_COL] = bit_col_i;

    main_if.set[MAIN_REST] = disturbance_frame_i;
  end

  // timer and field register sources
  always_comb begin
    tf_if.set = 8'h00;

    tf_if.set[TF_DCT] = cmd_done_i;
    tf_if.set[TF_NRE] = nrt_expire_i;
    tf_if.set[TF_GPE] = gpt_expire_i;

    // a drop is a rise of the inverted field level
    // field rise and drop
    tf_if.set[TF_EON] = rise(ext_field_i, field_q);
    tf_if.set[TF_EOF] = rise(field_q, ext_field_i);

    tf_if.set[TF_CAC] = ca_collision_i;

    tf_if.set[TF_CAT] = guard_done;

    tf_if.set[TF_RATE] = bitrate_found_i;
  end

  // error and wake-up register sources
  always_comb begin
    err_if.set = 8'h00;

    err_if.set[ERR_CRC] = crc_err_i;
    err_if.set[ERR_PAR] = parity_err_i;
    err_if.set[ERR_SOFT] = soft_framing_i;

    err_if.set[ERR_HARD] = hard_framing_i;

    // the option gates the event, so a flag already set stays
    // wake timer option gate
    err_if.set[ERR_WT] = wake_timeout_i & wake_every_i;

    err_if.set[ERR_WAM] = wake_amp_i;
    err_if.set[ERR_WPH] = wake_phase_i;
    err_if.set[ERR_WCAP] = wake_cap_i;
  end

  // passive target register sources
  always_comb begin
    tgt_if.set = 8'h00;

    tgt_if.set[TGT_SLOT] = rise(slot_low, slot_low_q);

    tgt_if.set[TGT_APON] = ca_field_on_i;

    tgt_if.set[TGT_RXE] = pt_auto_resp_i;

    tgt_if.set[TGT_FACT] = nfcf_resp_sent_i;

    tgt_if.set[TGT_ASTAR] = enter_act_star;
    tgt_if.set[TGT_ACT] = enter_act;
  end

  // read decode; a read with the enable low is dropped whole
  assign rd_main = reg_rd_i & (reg_addr_i == ADDR_MAIN);
  assign rd_tf = reg_rd_i & (reg_addr_i == ADDR_TF);
  assign rd_tgt = reg_rd_i & (reg_addr_i == ADDR_TGT);

  assign tf_if.clr = {8{rd_tf}};
  assign tgt_if.clr = {8{rd_tgt}};
  // main read clears main and error
  assign main_if.clr = {8{rd_main}};
  assign err_if.clr = {8{rd_main}};

  // mask and guard step registers, written by software
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mask_main_q <= MASK_RST;
      mask_tf_q <= MASK_RST;
      mask_err_q <= MASK_RST;
      mask_tgt_q <= MASK_RST;
      guard_q <= GUARD_RST;
    end else if (ce_i && reg_wr_i) begin
      unique case (reg_addr_i)
        ADDR_GUARD: guard_q <= reg_wdata_i;
        // reserved mask bits are dropped so they read back as zero
        ADDR_MASK_MAIN: mask_main_q <= reg_wdata_i & MAIN_USED;
        ADDR_MASK_TF: mask_tf_q <= reg_wdata_i & TF_USED;
        ADDR_MASK_ERR: mask_err_q <= reg_wdata_i & ERR_USED;
        ADDR_MASK_TGT: mask_tgt_q <= reg_wdata_i & TGT_USED;
        // flag registers are read-only; other addresses ignore writes
        default: begin
        end
      endcase
    end
  end

  // read data: value before the clear, valid the cycle after the strobe
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_q <= 8'h00;
    end else if (ce_i) begin
      if (reg_rd_i) begin
        unique case (reg_addr_i)
          ADDR_GUARD: rdata_q <= guard_q;
          ADDR_MASK_MAIN: rdata_q <= mask_main_q;
          ADDR_MASK_TF: rdata_q <= mask_tf_q;
          ADDR_MASK_ERR: rdata_q <= mask_err_q;
          ADDR_MASK_TGT: rdata_q <= mask_tgt_q;
          ADDR_MAIN: rdata_q <= main_if.flags;
          ADDR_TF: rdata_q <= tf_if.flags;
          ADDR_ERR: rdata_q <= err_if.flags;
          ADDR_TGT: rdata_q <= tgt_if.flags;
          // unmapped places read zero
          default: rdata_q <= 8'h00;
        endcase
      end else begin
        rdata_q <= 8'h00;
      end
    end
  end

  // request follows stored flags and masks, so it drops only after the clearing read or a mask write
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_q <= 1'b0;
    end else if (ce_i) begin
      irq_q <= |(main_if.flags & ~mask_main_q) |
               |(tf_if.flags & ~mask_tf_q) |
               |(err_if.flags & ~mask_err_q) |
               |(tgt_if.flags & ~mask_tgt_q);
    end
  end

  assign reg_rdata_o = rdata_q;
  assign irq_o = irq_q;

endmodule : nif_flags_top
`default_nettype wire

// *** nif_flags_props.sv ***
// concurrent checks on the ports of the nfc interrupt flag block
`timescale 1ns/1ps
`default_nettype none
module nif_flags_props
  import nif_pkg::*;
(
  // clock, reset, enable
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  // watched event sources
  input wire logic osc_en_i,
  input wire logic osc_stable_i,
  input wire logic rx_start_i,
  input wire logic cmd_done_i,
  input wire logic crc_err_i,
  input wire logic wake_timeout_i,
  input wire logic wake_every_i,
  // request
  input wire logic irq_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  // decoded reads; a strobe with the enable low is lost anyway
  wire logic rd_main = ce_i && reg_rd_i && reg_addr_i == ADDR_MAIN;
  wire logic rd_tf = ce_i && reg_rd_i && reg_addr_i == ADDR_TF;
  wire logic rd_err = ce_i && reg_rd_i && reg_addr_i == ADDR_ERR;
  logic [7:0] mmask_q;

  // shadow of the main mask, so irq checks know which sources count
  always_ff @(posedge mclk_i or negedge nrst_i)
    if (!nrst_i)
      mmask_q <= MASK_RST;
    else if (ce_i && reg_wr_i && reg_addr_i == ADDR_MASK_MAIN)
      mmask_q <= reg_wdata_i;

  AST_RDATA_IDLE: assert property (ce_i && !reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data not zero outside a read");
  AST_OSC_FLAG: assert property ($past(osc_en_i) && osc_en_i && $rose(osc_stable_i)
    ##2 rd_main |=> reg_rdata_o[MAIN_OSC]) else $error("oscillator flag missing");
  AST_RXS_LATCH: assert property (ce_i && rx_start_i ##2 rd_main |=> reg_rdata_o[MAIN_RXS])
    else $error("rx start flag missing");
  AST_TF_CLEAR: assert property ((rd_tf && !cmd_done_i) [*2] |=> !reg_rdata_o[TF_DCT])
    else $error("timer flag survived its read");
  AST_ERR_HOLD: assert property (rd_err ##1 rd_err
    |=> reg_rdata_o[ERR_CRC] || !$past(reg_rdata_o[ERR_CRC])) else $error("error flag lost");
  AST_ERR_CLEAR: assert property (rd_main && !crc_err_i ##1 rd_err && !crc_err_i
    |=> !reg_rdata_o[ERR_CRC]) else $error("error flag not cleared by main read");
  AST_WT_GATE: assert property (rd_main && wake_timeout_i && !wake_every_i
    ##1 rd_err && !wake_timeout_i |=> !reg_rdata_o[ERR_WT]) else $error("wake flag set");
  AST_IRQ_SET: assert property (ce_i && rx_start_i && !mmask_q[MAIN_RXS] |-> ##2 irq_o)
    else $error("request not raised");
  AST_IRQ_HOLD: assert property ((ce_i && !reg_rd_i && !reg_wr_i) [*2] ##0 irq_o
    |=> irq_o) else $error("request dropped without a read");
endmodule : nif_flags_props

bind nif_flags_top nif_flags_props u_props (.mclk_i, .nrst_i, .ce_i, .reg_addr_i, .reg_wdata_i,
  .reg_wr_i, .reg_rd_i, .reg_rdata_o, .osc_en_i, .osc_stable_i, .rx_start_i, .cmd_done_i,
  .crc_err_i, .wake_timeout_i, .wake_every_i, .irq_o);
`default_nettype wire

// *** nif_host_model.sv ***
// host model: single writes and back-to-back read pairs on the register port
`timescale 1ns/1ps
`default_nettype none
module nif_host_model (
  // clock
  input wire logic mclk_i,
  // register port toward the block
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  input wire logic [7:0] reg_rdata_i
);
  // idle bus from time zero
  initial begin
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end

  // one-cycle write strobe; the slave never stalls
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_wr_o <= 1'b1;
    @(posedge mclk_i);
    reg_wr_o <= 1'b0;
  endtask : wr

  // two reads with no gap; each answer stands only in the following cycle
  task automatic rd2(input logic [7:0] a0, input logic [7:0] a1,
                     output logic [7:0] d0, output logic [7:0] d1);
    @(posedge mclk_i);
    reg_addr_o <= a0;
    reg_rd_o <= 1'b1;
    @(posedge mclk_i);
    reg_addr_o <= a1;
    #1 d0 = reg_rdata_i;
    @(posedge mclk_i);
    reg_rd_o <= 1'b0;
    #1 d1 = reg_rdata_i;
  endtask : rd2
endmodule : nif_host_model
`default_nettype wire

// *** test_nif_flags_top.sv ***
// self-checking bench for the nfc interrupt flag block
`timescale 1ns/1ps
`default_nettype none
module test_nif_flags_top;
  import nif_pkg::*;
  // short guard timing keeps the run brief
  localparam int GB = 5;
  localparam int GS = 3;
  // register of each pulse source and its flag bit; entry 9 is the guard start
  localparam logic [7:0] EA [21] = '{ADDR_MAIN, ADDR_MAIN, ADDR_MAIN, ADDR_MAIN, ADDR_MAIN,
    ADDR_TF, ADDR_TF, ADDR_TF, ADDR_TF, ADDR_TGT, ADDR_TF, ADDR_ERR, ADDR_ERR, ADDR_ERR,
    ADDR_ERR, ADDR_ERR, ADDR_ERR, ADDR_ERR, ADDR_ERR, ADDR_TGT, ADDR_TGT};
  localparam int EB [21] = '{5, 4, 3, 2, 1, 7, 6, 5, 2, 5, 0, 7, 6, 5, 4, 3, 2, 1, 0, 4, 3};

  logic mclk_i;
  logic nrst_i;
  wire logic [7:0] reg_addr_i;
  wire logic [7:0] reg_wdata_i;
  wire logic reg_wr_i;
  wire logic reg_rd_i;
  wire logic [7:0] reg_rdata_o;
  wire logic irq_o;
  logic osc_en_i = 1'b0, osc_stable_i = 1'b0, rx_active_i = 1'b0, tx_active_i = 1'b0;
  logic ce_i = 1'b1, ext_field_i = 1'b0, wake_every_i = 1'b0;
  logic [9:0] fifo_count_i = 10'h000;
  logic [4:0] unused_slots_i = 5'h00;
  logic [3:0] pta_state_i = 4'h0;
  logic [20:0] ev = 21'h000000;
  int error_cnt = 0;
  int checks_done = 0;

  // block under test
  nif_flags_top #(.GUARD_BASE_CYCLES(GB), .GUARD_STEP_CYCLES(GS)) i_nif_flags_top (
    .mclk_i, .nrst_i, .ce_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .osc_en_i, .osc_stable_i, .rx_active_i, .tx_active_i, .fifo_count_i,
    .rx_start_i(ev[0]), .rx_end_i(ev[1]), .tx_end_i(ev[2]), .bit_col_i(ev[3]),
    .disturbance_frame_i(ev[4]), .cmd_done_i(ev[5]), .nrt_expire_i(ev[6]),
    .gpt_expire_i(ev[7]), .ext_field_i, .ca_collision_i(ev[8]), .ca_field_on_i(ev[9]),
    .bitrate_found_i(ev[10]), .crc_err_i(ev[11]), .parity_err_i(ev[12]),
    .soft_framing_i(ev[13]), .hard_framing_i(ev[14]), .wake_timeout_i(ev[15]),
    .wake_every_i, .wake_amp_i(ev[16]), .wake_phase_i(ev[17]), .wake_cap_i(ev[18]),
    .unused_slots_i, .pt_auto_resp_i(ev[19]), .nfcf_resp_sent_i(ev[20]), .pta_state_i,
    .irq_o);

  // host on the register port
  nif_host_model i_host (.mclk_i, .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i),
    .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_rdata_i(reg_rdata_o));

  // 125 mhz clock
  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  // one-cycle event pulse
  task automatic pulse(input int n);
    @(posedge mclk_i);
    ev[n] <= 1'b1;
    @(posedge mclk_i);
    ev[n] <= 1'b0;
  endtask : pulse

  // let a level change land, then read a clear-on-read register twice
  task automatic lvl(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d0, d1;
    @(posedge mclk_i);
    i_host.rd2(a, a, d0, d1);
    chk(d0, e);
    chk(d1, 8'h00);
  endtask : lvl

  // reset values, access kinds, reserved bits, unmapped place
  task automatic t_regs();
    logic [7:0] d0, d1, e;
    logic [7:0] used [4] = '{MAIN_USED, TF_USED, ERR_USED, TGT_USED};
    chk({7'h00, irq_o}, 8'h00);
    i_host.wr(8'h3f, 8'hff);
    for (int a = 8'h15; a <= 8'h1d; a++) begin
      i_host.rd2(8'(a), 8'h3f, d0, d1);
      chk(d0, (a == 8'h15) ? GUARD_RST : 8'h00);
      chk(d1, 8'h00);
      i_host.wr(8'(a), 8'hff);
      i_host.rd2(8'(a), 8'(a), d0, d1);
      e = (a > 8'h19) ? 8'h00 : (a == 8'h15) ? 8'hff : used[a - 8'h16];
      chk(d0, e);
    end
    for (int a = 8'h16; a <= 8'h19; a++)
      i_host.wr(8'(a), 8'h00);
  endtask : t_regs

  // timeout with the every-timeout option off lands beside a main read
  task automatic t_wake_gate();
    logic [7:0] d0, d1;
    fork
      i_host.rd2(ADDR_MAIN, ADDR_ERR, d0, d1);
      pulse(15);
    join
    chk(d1, 8'h00);
  endtask : t_wake_gate

  // every pulse source but the guard start, its read-clear or hold, then the main-read clear
  task automatic t_events();
    logic [7:0] d0, d1, e;
    @(posedge mclk_i);
    wake_every_i <= 1'b1;
    for (int i = 0; i < 21; i++) begin
      if (i != 9) begin
        pulse(i);
        i_host.rd2(EA[i], EA[i], d0, d1);
        e = 8'h01 << EB[i];
        chk(d0, e);
        chk(d1, (EA[i] == ADDR_ERR) ? e : 8'h00);
        i_host.rd2(ADDR_MAIN, ADDR_ERR, d0, d1);
        chk(d1, 8'h00);
        repeat (2) @(posedge mclk_i);
        #1 chk({7'h00, irq_o}, 8'h00);
      end
    end
  endtask : t_events

  // masked source stays quiet, unmask raises, read releases
  task automatic t_irq();
    logic [7:0] d0, d1;
    i_host.wr(ADDR_MASK_MAIN, 8'h20);
    pulse(0);
    repeat (3) @(posedge mclk_i);
    #1 chk({7'h00, irq_o}, 8'h00);
    i_host.wr(ADDR_MASK_MAIN, 8'h00);
    repeat (2) @(posedge mclk_i);
    #1 chk({7'h00, irq_o}, 8'h01);
    i_host.rd2(ADDR_MAIN, ADDR_MAIN, d0, d1);
    repeat (2) @(posedge mclk_i);
    #1 chk({7'h00, irq_o}, 8'h00);
  endtask : t_irq

  // enable low freezes the flags: an event in that cycle is lost
  task automatic t_ce();
    logic [7:0] d0, d1;
    @(posedge mclk_i);
    ce_i <= 1'b0;
    pulse(0);
    ce_i <= 1'b1;
    i_host.rd2(ADDR_MAIN, ADDR_MAIN, d0, d1);
    chk(d0, 8'h00);
  endtask : t_ce

  // level sources at their boundaries; flags fire on entry only
  task automatic t_levels();
    @(posedge mclk_i);
    osc_en_i <= 1'b1;
    lvl(ADDR_MAIN, 8'h00);
    @(posedge mclk_i);
    osc_stable_i <= 1'b1;
    lvl(ADDR_MAIN, 8'h80);
    @(posedge mclk_i);
    rx_active_i <= 1'b1;
    fifo_count_i <= 10'h12c;
    lvl(ADDR_MAIN, 8'h00);
    @(posedge mclk_i);
    fifo_count_i <= 10'h12d;
    lvl(ADDR_MAIN, 8'h40);
    @(posedge mclk_i);
    rx_active_i <= 1'b0;
    tx_active_i <= 1'b1;
    fifo_count_i <= 10'h0c8;
    lvl(ADDR_MAIN, 8'h00);
    @(posedge mclk_i);
    fifo_count_i <= 10'h0c7;
    lvl(ADDR_MAIN, 8'h40);
    @(posedge mclk_i);
    ext_field_i <= 1'b1;
    lvl(ADDR_TF, 8'h10);
    @(posedge mclk_i);
    ext_field_i <= 1'b0;
    lvl(ADDR_TF, 8'h08);
    @(posedge mclk_i);
    unused_slots_i <= 5'h05;
    lvl(ADDR_TGT, 8'h00);
    @(posedge mclk_i);
    unused_slots_i <= 5'h04;
    lvl(ADDR_TGT, 8'h40);
    @(posedge mclk_i);
    pta_state_i <= 4'h5;
    lvl(ADDR_TGT, 8'h01);
    @(posedge mclk_i);
    pta_state_i <= 4'hd;
    lvl(ADDR_TGT, 8'h02);
  endtask : t_levels

  // guard flag must not show one cycle early; field-on flag at once
  task automatic t_guard();
    logic [7:0] d0, d1;
    i_host.wr(ADDR_GUARD, 8'h02);
    pulse(9);
    repeat (GB + 2 * GS + 2 - 3) @(posedge mclk_i);
    i_host.rd2(ADDR_TF, ADDR_TF, d0, d1);
    chk(d0, 8'h00);
    chk(d1, 8'h02);
    i_host.rd2(ADDR_TGT, ADDR_TGT, d0, d1);
    chk(d0, 8'h20);
  endtask : t_guard

  // watchdog against a hung sequence
  initial begin
    repeat (20000) @(posedge mclk_i);
    error_cnt++;
    wrap_up();
  end

  // reset, then the scenarios in turn
  initial begin
    nrst_i = 1'b0;
    repeat (16) @(posedge mclk_i);
    nrst_i <= 1'b1;
    t_regs();
    t_wake_gate();
    t_events();
    t_irq();
    t_ce();
    t_levels();
    t_guard();
    wrap_up();
  end
endmodule : test_nif_flags_top
`default_nettype wire
